// File: hw/dpat_regs.vh
`ifndef DPAT_REGS_VH
`define DPAT_REGS_VH

// Alarm action encodings
`define DPAT_ACT_DIS 3'h0
`define DPAT_ACT_ONLY 3'h1
`define DPAT_ACT_STOP 3'h2
`define DPAT_ACT_MALF 3'h3
`define DPAT_ACT_DRV 3'h4

// Configuration reset values
`define DPAT_PPU_RST 20'h0_0001
`define DPAT_RINT_RST 11'h001
`define DPAT_PER_RST 9'h001
`define DPAT_DLY_RST 8'h00
`define DPAT_ID_RST 8'h00

// Timebase figures
`define DPAT_MIN_PER_DAY 32'h0000_05A0
`define DPAT_HIST_DAYS 9'h03C
`define DPAT_HIST_LAST 6'h3B
`define DPAT_HIST_WORDS 480
`define DPAT_DIV_STEPS 6'h20

`endif

// File: hw/dpat_core.v
`timescale 1ns/1ps
`default_nettype none
`include "dpat_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module dpat_core (
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Timebase strobes, one cycle each
  input wire i_sec_tick,
  input wire i_min_tick,
  input wire i_day_tick,
  // Discrete point pins
  input wire [7:0] i_pt_pin,
  output wire [7:0] o_pt_out,
  output wire [7:0] o_pt_oe,
  input wire [7:0] i_pt_cmd,
  // Discrete point configuration write
  input wire i_pt_wr,
  input wire [2:0] i_pt_sel,
  input wire i_pt_dir,
  input wire [7:0] i_pt_id,
  input wire [2:0] i_pt_action,
  input wire [2:0] i_pt_target,
  input wire i_pt_pol,
  input wire [7:0] i_pt_delay,
  // Alarm control and status
  input wire i_alarm_clr,
  output wire [7:0] o_pt_raw,
  output wire [7:0] o_pt_state,
  output wire [7:0] o_alarm_pts,
  output wire o_motor_stop,
  output wire o_malf_evt,
  output wire [2:0] o_malf_pt,
  input wire [2:0] i_pt_rsel,
  output wire [7:0] o_pt_id,
  // Pulse transmitter pins
  input wire [7:0] i_pulse,
  // Totalizer configuration write
  input wire i_tot_wr,
  input wire [2:0] i_tot_sel,
  input wire [7:0] i_tot_id,
  input wire [19:0] i_tot_ppu,
  input wire [4:0] i_tot_unit,
  input wire [10:0] i_tot_rint,
  input wire [8:0] i_tot_per,
  // Totalizer clear commands
  input wire i_tot_clr,
  input wire i_per_clr,
  input wire [2:0] i_clr_sel,
  // Totalizer status read
  input wire [2:0] i_tot_rsel,
  input wire [5:0] i_hist_idx,
  output wire [7:0] o_tot_id,
  output wire [4:0] o_tot_unit,
  output wire [31:0] o_tot_total,
  output wire [31:0] o_tot_period,
  output wire [31:0] o_tot_prev,
  output wire [31:0] o_tot_rate,
  output wire [15:0] o_tot_freq,
  output wire [31:0] o_hist_val
);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration storage
  reg [7:0] pt_dir_r;
  reg [7:0] pt_pol_r;
  reg [7:0] pt_id_r [0:7];
  reg [2:0] pt_act_r [0:7];
  reg [2:0] pt_tgt_r [0:7];
  reg [7:0] pt_dly_r [0:7];
  reg [7:0] tc_id_r [0:7];
  reg [19:0] tc_ppu_r [0:7];
  reg [4:0] tc_unit_r [0:7];
  reg [10:0] tc_rint_r [0:7];
  reg [8:0] tc_per_r [0:7];
  // One loop index per process, so no variable has two drivers
  integer k;
  integer kd;
  integer ko;
  integer kh;
  integer kp;
  integer kv;

  // Writes land at the selected index; everything resets to safe values
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      pt_dir_r <= 8'h00;
      pt_pol_r <= 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        pt_id_r[k] <= `DPAT_ID_RST;
        pt_act_r[k] <= `DPAT_ACT_DIS;
        pt_tgt_r[k] <= 3'h0;
        pt_dly_r[k] <= `DPAT_DLY_RST;
        tc_id_r[k] <= `DPAT_ID_RST;
        tc_ppu_r[k] <= `DPAT_PPU_RST;
        tc_unit_r[k] <= 5'h00;
        tc_rint_r[k] <= `DPAT_RINT_RST;
        tc_per_r[k] <= `DPAT_PER_RST;
      end
    end else begin
      if (i_pt_wr) begin
        pt_dir_r[i_pt_sel] <= i_pt_dir;
        pt_pol_r[i_pt_sel] <= i_pt_pol;
        pt_id_r[i_pt_sel] <= i_pt_id;
        pt_act_r[i_pt_sel] <= i_pt_action;
        // Target is kept only while output-drive is the chosen action
        pt_tgt_r[i_pt_sel] <= (i_pt_action == `DPAT_ACT_DRV) ? i_pt_target : 3'h0;
        pt_dly_r[i_pt_sel] <= i_pt_delay;
      end
      if (i_tot_wr) begin
        tc_id_r[i_tot_sel] <= i_tot_id;
        // Zero would divide by nothing, so it is held at one
        tc_ppu_r[i_tot_sel] <= (i_tot_ppu == 20'h0_0000) ? `DPAT_PPU_RST : i_tot_ppu;
        tc_unit_r[i_tot_sel] <= i_tot_unit;
        tc_rint_r[i_tot_sel] <= i_tot_rint;
        tc_per_r[i_tot_sel] <= (i_tot_per == 9'h000) ? `DPAT_PER_RST : i_tot_per;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; pulse edge is found between the second and third stages
  reg [7:0] pin_s1_r;
  reg [7:0] pin_s2_r;
  reg [7:0] pls_s1_r;
  reg [7:0] pls_s2_r;
  reg [7:0] pls_s3_r;

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pls_s1_r <= 8'h00;
      pls_s2_r <= 8'h00;
      pls_s3_r <= 8'h00;
    end else begin
      pin_s1_r <= i_pt_pin;
      pin_s2_r <= pin_s1_r;
      pls_s1_r <= i_pulse;
      pls_s2_r <= pls_s1_r;
      pls_s3_r <= pls_s2_r;
    end
  end

  assign o_pt_raw = pin_s2_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-point debounce and alarm evaluation
  wire [7:0] filt;
  wire [7:0] alm;
  reg [7:0] drv;
  reg [7:0] dt_r;
  reg [7:0] alm_d_r;
  reg [7:0] malf_r;
  genvar gi;

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pt
      reg [7:0] dbc_r;
      reg filt_r;
      // Outputs and zero-delay inputs follow the pin directly; other inputs need a steady run of seconds
      always @(posedge i_mclk) begin
        if (!i_nrst) begin
          dbc_r <= 8'h00;
          filt_r <= 1'b0;
        end else if (pt_dir_r[gi] || pt_dly_r[gi] == 8'h00) begin
          dbc_r <= 8'h00;
          filt_r <= pin_s2_r[gi];
        end else if (pin_s2_r[gi] == filt_r) begin
          dbc_r <= 8'h00; // Any bounce back restarts the wait
        end else if (i_sec_tick) begin
          if (dbc_r + 8'h01 >= pt_dly_r[gi]) begin
            filt_r <= pin_s2_r[gi];
            dbc_r <= 8'h00;
          end else begin
            dbc_r <= dbc_r + 8'h01;
          end
        end
      end
      assign filt[gi] = filt_r;
      // Pin high reads as closed; polarity picks which state alarms
      assign alm[gi] = ~pt_dir_r[gi] & (filt_r == pt_pol_r[gi]) &
                       (pt_act_r[gi] != `DPAT_ACT_DIS);
    end
  endgenerate

  assign o_pt_state = filt;
  assign o_alarm_pts = alm;

  // Output-drive requests gathered per target point
  always @* begin
    drv = 8'h00;
    for (kd = 0; kd < 8; kd = kd + 1) begin
      if (alm[kd] && pt_act_r[kd] == `DPAT_ACT_DRV) begin
        drv[pt_tgt_r[kd]] = 1'b1;
      end
    end
  end

  // Downtime latch, malfunction pulse and output pin drive
  reg [7:0] out_r;
  reg [7:0] oe_r;
  reg [2:0] malf_pt_r;

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      dt_r <= 8'h00;
      alm_d_r <= 8'h00;
      malf_r <= 8'h00;
      malf_pt_r <= 3'h0;
      out_r <= 8'h00;
      oe_r <= 8'h00;
    end else begin
      alm_d_r <= alm;
      for (ko = 0; ko < 8; ko = ko + 1) begin
        // Set wins: a live alarm keeps downtime through a clear request
        if (alm[ko] && pt_act_r[ko] == `DPAT_ACT_STOP) begin
          dt_r[ko] <= 1'b1;
        end else if (i_alarm_clr) begin
          dt_r[ko] <= 1'b0;
        end
        malf_r[ko] <= alm[ko] & ~alm_d_r[ko] & (pt_act_r[ko] == `DPAT_ACT_MALF);
        if (alm[ko] && ~alm_d_r[ko] && pt_act_r[ko] == `DPAT_ACT_MALF) begin
          malf_pt_r <= ko[2:0];
        end
      end
      // Drive only points set as outputs; inputs stay released
      oe_r <= pt_dir_r;
      out_r <= pt_dir_r & (i_pt_cmd | drv);
    end
  end

  assign o_motor_stop = |dt_r;
  assign o_malf_evt = |malf_r;
  assign o_malf_pt = malf_pt_r;
  assign o_pt_out = out_r;
  assign o_pt_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Totalizer channels
  reg [31:0] tot_r [0:7];
  reg [31:0] per_r [0:7];
  reg [31:0] prev_r [0:7];
  reg [31:0] day_r [0:7];
  reg [15:0] freq_r [0:7];
  wire [7:0] unit;
  wire [7:0] iv_done;
  wire [31:0] iv_val [0:7];

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_tc
      reg [19:0] rem_r;
      reg [10:0] ivm_r;
      reg [31:0] ivu_r;
      reg [15:0] fcnt_r;
      reg [8:0] dayc_r;
      wire edge_w = pls_s2_r[gi] & ~pls_s3_r[gi];
      wire per_end = i_day_tick && (dayc_r + 9'h001 >= tc_per_r[gi]);
      wire [31:0] inc = {31'h0000_0000, unit[gi]};
      assign unit[gi] = edge_w && (rem_r + 20'h0_0001 >= tc_ppu_r[gi]);
      assign iv_done[gi] = i_min_tick && tc_rint_r[gi] != 11'h000 &&
                           (ivm_r + 11'h001 >= tc_rint_r[gi]);
      assign iv_val[gi] = ivu_r + inc;

      always @(posedge i_mclk) begin
        if (!i_nrst) begin
          rem_r <= 20'h0_0000;
          ivm_r <= 11'h000;
          ivu_r <= 32'h0000_0000;
          fcnt_r <= 16'h0000;
          dayc_r <= 9'h000;
          tot_r[gi] <= 32'h0000_0000;
          per_r[gi] <= 32'h0000_0000;
          prev_r[gi] <= 32'h0000_0000;
          day_r[gi] <= 32'h0000_0000;
          freq_r[gi] <= 16'h0000;
        end else begin
          // Remainder of pulses short of one unit
          if (unit[gi]) begin
            rem_r <= 20'h0_0000;
          end else if (edge_w) begin
            rem_r <= rem_r + 20'h0_0001;
          end
          // Pulses per second, latched each second
          if (i_sec_tick) begin
            freq_r[gi] <= fcnt_r + {15'h0000, edge_w};
            fcnt_r <= 16'h0000;
          end else if (edge_w) begin
            fcnt_r <= fcnt_r + 16'h0001;
          end
          // Overall total
          if (i_tot_clr && i_clr_sel == gi) begin
            tot_r[gi] <= 32'h0000_0000;
          end else begin
            tot_r[gi] <= tot_r[gi] + inc;
          end
          // Period total: a unit in the closing cycle belongs to that period
          if (per_end) begin
            prev_r[gi] <= per_r[gi] + inc;
            per_r[gi] <= 32'h0000_0000;
            dayc_r <= 9'h000;
          end else begin
            if (i_day_tick) begin
              dayc_r <= dayc_r + 9'h001;
            end
            if (i_per_clr && i_clr_sel == gi) begin
              per_r[gi] <= 32'h0000_0000;
            end else begin
              per_r[gi] <= per_r[gi] + inc;
            end
          end
          // Daily total restarts at each cutoff
          day_r[gi] <= i_day_tick ? 32'h0000_0000 : day_r[gi] + inc;
          // Sampling interval
          if (tc_rint_r[gi] == 11'h000 || iv_done[gi]) begin
            ivm_r <= 11'h000;
            ivu_r <= 32'h0000_0000;
          end else begin
            if (i_min_tick) begin
              ivm_r <= ivm_r + 11'h001;
            end
            ivu_r <= ivu_r + inc;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Daily history: one ring slot per day for each channel, write pointer shared by all channels
  reg [31:0] hist_r [0:`DPAT_HIST_WORDS-1];
  reg [5:0] wp_r;

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      wp_r <= 6'h00;
    end else if (i_day_tick) begin
      wp_r <= (wp_r == `DPAT_HIST_LAST) ? 6'h00 : wp_r + 6'h01;
    end
  end

  // History RAM has no reset; unwritten slots are not meaningful
  always @(posedge i_mclk) begin
    if (i_day_tick) begin
      for (kh = 0; kh < 8; kh = kh + 1) begin
        hist_r[kh[8:0] * `DPAT_HIST_DAYS + {3'h0, wp_r}] <=
          day_r[kh] + {31'h0000_0000, unit[kh]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared serial divider for the daily rate, 32 cycles per channel
  reg [7:0] pend_r;
  reg [31:0] lat_r [0:7];
  reg [31:0] rate_r [0:7];
  reg busy_r;
  reg [2:0] dch_r;
  reg [5:0] dcnt_r;
  reg [31:0] dnum_r;
  reg [31:0] dq_r;
  reg [31:0] drem_r;
  reg [10:0] dden_r;
  reg [2:0] pick;
  reg found;
  wire [32:0] dtry = {drem_r, dnum_r[31]};

  // Lowest pending channel goes next; intervals are minutes apart, so no starve
  always @* begin
    pick = 3'h0;
    found = 1'b0;
    for (kp = 7; kp >= 0; kp = kp - 1) begin
      if (pend_r[kp]) begin
        pick = kp[2:0];
        found = 1'b1;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      pend_r <= 8'h00;
      busy_r <= 1'b0;
      dch_r <= 3'h0;
      dcnt_r <= 6'h00;
      dnum_r <= 32'h0000_0000;
      dq_r <= 32'h0000_0000;
      drem_r <= 32'h0000_0000;
      dden_r <= 11'h001;
      for (kv = 0; kv < 8; kv = kv + 1) begin
        lat_r[kv] <= 32'h0000_0000;
        rate_r[kv] <= 32'h0000_0000;
      end
    end else begin
      for (kv = 0; kv < 8; kv = kv + 1) begin
        if (tc_rint_r[kv] == 11'h000) begin
          rate_r[kv] <= 32'h0000_0000;
        end
        if (iv_done[kv]) begin
          lat_r[kv] <= iv_val[kv] * `DPAT_MIN_PER_DAY;
        end
      end
      if (!busy_r && found) begin
        busy_r <= 1'b1;
        dch_r <= pick;
        dcnt_r <= 6'h00;
        dnum_r <= lat_r[pick];
        dden_r <= tc_rint_r[pick];
        drem_r <= 32'h0000_0000;
        dq_r <= 32'h0000_0000;
      end else if (busy_r) begin
        // Restoring step: shift in a numerator bit, subtract if it fits
        dnum_r <= {dnum_r[30:0], 1'b0};
        if (dtry >= {22'h00_0000, dden_r}) begin
          drem_r <= dtry[31:0] - {21'h00_0000, dden_r};
          dq_r <= {dq_r[30:0], 1'b1};
        end else begin
          drem_r <= dtry[31:0];
          dq_r <= {dq_r[30:0], 1'b0};
        end
        dcnt_r <= dcnt_r + 6'h01;
        if (dcnt_r == `DPAT_DIV_STEPS - 6'h01) begin
          busy_r <= 1'b0;
          // A divisor zeroed mid-run leaves the rate at zero
          if (dden_r != 11'h000 && tc_rint_r[dch_r] != 11'h000) begin
            rate_r[dch_r] <= {dq_r[30:0], (dtry >= {22'h00_0000, dden_r})};
          end
        end
      end
      // Set wins over the clear of the channel now starting
      for (kv = 0; kv < 8; kv = kv + 1) begin
        if (iv_done[kv]) begin
          pend_r[kv] <= 1'b1;
        end else if (!busy_r && found && pick == kv) begin
          pend_r[kv] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered status read for the selected point and channel
  reg [7:0] rd_pid_r;
  reg [7:0] rd_tid_r;
  reg [4:0] rd_unit_r;
  reg [31:0] rd_tot_r;
  reg [31:0] rd_per_r;
  reg [31:0] rd_prev_r;
  reg [31:0] rd_rate_r;
  reg [15:0] rd_freq_r;
  reg [31:0] rd_hist_r;
  // Flat slot: channel times days, plus the day slot
  wire [8:0] ridx = {6'h00, i_tot_rsel} * `DPAT_HIST_DAYS + {3'h0, i_hist_idx};

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      rd_pid_r <= 8'h00;
      rd_tid_r <= 8'h00;
      rd_unit_r <= 5'h00;
      rd_tot_r <= 32'h0000_0000;
      rd_per_r <= 32'h0000_0000;
      rd_prev_r <= 32'h0000_0000;
      rd_rate_r <= 32'h0000_0000;
      rd_freq_r <= 16'h0000;
      rd_hist_r <= 32'h0000_0000;
    end else begin
      rd_pid_r <= pt_id_r[i_pt_rsel];
      rd_tid_r <= tc_id_r[i_tot_rsel];
      rd_unit_r <= tc_unit_r[i_tot_rsel];
      rd_tot_r <= tot_r[i_tot_rsel];
      rd_per_r <= per_r[i_tot_rsel];
      rd_prev_r <= prev_r[i_tot_rsel];
      rd_rate_r <= rate_r[i_tot_rsel];
      rd_freq_r <= freq_r[i_tot_rsel];
      // Index beyond the last day reads zero
      rd_hist_r <= (i_hist_idx > `DPAT_HIST_LAST) ? 32'h0000_0000 : hist_r[ridx];
    end
  end

  assign o_pt_id = rd_pid_r;
  assign o_tot_id = rd_tid_r;
  assign o_tot_unit = rd_unit_r;
  assign o_tot_total = rd_tot_r;
  assign o_tot_period = rd_per_r;
  assign o_tot_prev = rd_prev_r;
  assign o_tot_rate = rd_rate_r;
  assign o_tot_freq = rd_freq_r;
  assign o_hist_val = rd_hist_r;

endmodule // dpat_core

`default_nettype wire

// File: dv/dpat_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dpat_core_monitor (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Watched inputs
  input wire logic [7:0] i_pt_pin,
  input wire logic [7:0] i_pt_cmd,
  input wire logic i_pt_wr,
  input wire logic [2:0] i_pt_sel,
  input wire logic i_pt_dir,
  input wire logic i_alarm_clr,
  // Watched outputs
  input wire logic [7:0] o_pt_out,
  input wire logic [7:0] o_pt_oe,
  input wire logic [7:0] o_pt_raw,
  input wire logic [7:0] o_alarm_pts,
  input wire logic o_motor_stop,
  input wire logic o_malf_evt,
  input wire logic [2:0] o_malf_pt
);
  logic [1:0] up_r;
  // Edges since reset release, so history checks skip samples taken in reset
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  a_dir_sets_oe: assert property (
    i_pt_wr |-> ##2 o_pt_oe[$past(i_pt_sel, 2)] == $past(i_pt_dir, 2))
    else $error("output enable does not follow direction");
  a_raw_unfiltered: assert property (
    up_r == 2'h3 |-> o_pt_raw == $past(i_pt_pin, 2))
    else $error("raw state is not the synced pin");
  a_cmd_drives_out: assert property (
    up_r != 2'h0 |-> ($past(i_pt_cmd) & o_pt_oe & ~o_pt_out) == 8'h00)
    else $error("commanded output point not driven");
  a_inputs_undriven: assert property (
    (o_pt_out & ~o_pt_oe) == 8'h00)
    else $error("drive value on an input point");
  a_stop_has_cause: assert property (
    $rose(o_motor_stop) |-> $past(o_alarm_pts) != 8'h00)
    else $error("motor stop without alarm");
  a_stop_holds: assert property (
    o_motor_stop && !i_alarm_clr |=> o_motor_stop)
    else $error("motor stop dropped without clear");
  a_malf_one_cycle: assert property (
    o_malf_evt |=> !o_malf_evt)
    else $error("malfunction event longer than one cycle");
  a_malf_has_alarm: assert property (
    o_malf_evt |-> o_alarm_pts[o_malf_pt])
    else $error("malfunction event on a point without alarm");
  // Main scenarios reached
  c_malf: cover property (o_malf_evt);
  c_stop: cover property ($rose(o_motor_stop));
  c_drive: cover property ((o_pt_out & o_pt_oe) != 8'h00);
endmodule // dpat_core_monitor
bind dpat_core dpat_core_monitor mon_u (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_pt_pin(i_pt_pin), .i_pt_cmd(i_pt_cmd),
  .i_pt_wr(i_pt_wr), .i_pt_sel(i_pt_sel), .i_pt_dir(i_pt_dir), .i_alarm_clr(i_alarm_clr),
  .o_pt_out(o_pt_out), .o_pt_oe(o_pt_oe), .o_pt_raw(o_pt_raw), .o_alarm_pts(o_alarm_pts),
  .o_motor_stop(o_motor_stop), .o_malf_evt(o_malf_evt), .o_malf_pt(o_malf_pt)
);
`default_nettype wire

// File: dv/dpat_field.sv
`timescale 1ns/1ps
`default_nettype none
module dpat_field (
  // Clock
  input wire logic i_mclk,
  // Switch levels and the block's drive
  input wire logic [7:0] i_sw,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  // Levels seen by the block
  output wire logic [7:0] o_pin,
  output logic [7:0] o_pulse
);
  // A driven point reads back its own drive, the rest show the switch
  assign o_pin = (i_oe & i_out) | (~i_oe & i_sw);
  initial o_pulse = 8'h00;
  ////////////////////////////////////////////////////////////
  // Two cycles high, two low, so the sync flops never miss an edge
  task automatic burst(input logic [7:0] mask, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      #1 o_pulse = mask;
      repeat (2) @(posedge i_mclk);
      #1 o_pulse = 8'h00;
      @(posedge i_mclk);
    end
  endtask
endmodule // dpat_field
`default_nettype wire

// File: dv/dpat_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpat_regs.vh"
module tb;
  // Stimulus, all valued at time zero
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sec = 1'b0, mn = 1'b0, dy = 1'b0, aclr = 1'b0, pwr = 1'b0, pdir = 1'b0;
  logic ppol = 1'b0, twr = 1'b0, tclr = 1'b0, pclr = 1'b0;
  logic [2:0] psel = 3'h0, pact = 3'h0, ptgt = 3'h0, prsel = 3'h0;
  logic [2:0] tsel = 3'h0, csel = 3'h0, trsel = 3'h0;
  logic [7:0] pcmd = 8'h00, pid = 8'h00, pdly = 8'h00, sw = 8'h00, tid = 8'h00;
  logic [19:0] ppu = 20'h0_0001;
  logic [4:0] unit = 5'h00;
  logic [10:0] rint = 11'h001;
  logic [8:0] per = 9'h001;
  logic [5:0] hidx = 6'h00;
  // Observed outputs
  wire logic [7:0] pin, pls, out, oe, raw, st, alm, ptid;
  wire logic stop, malf;
  wire logic [2:0] mpt;
  wire logic [31:0] total, prd, prev, rate, hist;
  wire logic [15:0] freq;
  wire logic [7:0] tido;
  wire logic [4:0] unito;
  int num_errors = 0;
  int samples_checked = 0;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
  ////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  dpat_field field_u (.i_mclk(clk), .i_sw(sw), .i_out(out), .i_oe(oe), .o_pin(pin),
    .o_pulse(pls));
  dpat_core dut_u (.i_mclk(clk), .i_nrst(nrst), .i_sec_tick(sec), .i_min_tick(mn),
    .i_day_tick(dy), .i_pt_pin(pin), .o_pt_out(out), .o_pt_oe(oe), .i_pt_cmd(pcmd),
    .i_pt_wr(pwr), .i_pt_sel(psel), .i_pt_dir(pdir), .i_pt_id(pid), .i_pt_action(pact),
    .i_pt_target(ptgt), .i_pt_pol(ppol), .i_pt_delay(pdly), .i_alarm_clr(aclr),
    .o_pt_raw(raw), .o_pt_state(st), .o_alarm_pts(alm), .o_motor_stop(stop),
    .o_malf_evt(malf), .o_malf_pt(mpt), .i_pt_rsel(prsel), .o_pt_id(ptid), .i_pulse(pls),
    .i_tot_wr(twr), .i_tot_sel(tsel), .i_tot_id(tid), .i_tot_ppu(ppu), .i_tot_unit(unit),
    .i_tot_rint(rint), .i_tot_per(per), .i_tot_clr(tclr), .i_per_clr(pclr),
    .i_clr_sel(csel), .i_tot_rsel(trsel), .i_hist_idx(hidx), .o_tot_id(tido),
    .o_tot_unit(unito),
    .o_tot_total(total), .o_tot_period(prd), .o_tot_prev(prev), .o_tot_rate(rate),
    .o_tot_freq(freq), .o_hist_val(hist));
  // Inputs always change 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tick(input logic [2:0] w);
    {sec, mn, dy} = w;
    step(1);
    {sec, mn, dy} = 3'h0;
    step(1);
  endtask
  task automatic pt(input logic [2:0] s, input logic d, input logic [2:0] a,
    input logic [2:0] t, input logic p, input logic [7:0] dl, input logic [7:0] id);
    {psel, pdir, pact, ptgt, ppol, pdly, pid} = {s, d, a, t, p, dl, id};
    pwr = 1'b1;
    step(1);
    pwr = 1'b0;
    step(1);
  endtask
  task automatic tw(input logic [2:0] s, input logic [4:0] u, input logic [19:0] p,
    input logic [10:0] r, input logic [8:0] d);
    {tsel, unit, ppu, rint, per} = {s, u, p, r, d};
    twr = 1'b1;
    step(1);
    twr = 1'b0;
    step(1);
  endtask
  task automatic clr(input logic [1:0] w);
    {tclr, pclr} = w;
    step(1);
    {tclr, pclr} = 2'h0;
    step(2);
  endtask
  task automatic fin(input string nm);
    $display("test %s done, mismatches so far %0d", nm, num_errors);
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin : main
    int i;
    step(5);
    nrst = 1'b1;
    step(1);
    `CHK("oe", 8'h00, oe)
    fin("reset");
    // Closed is alarm, three-second delay
    pt(3'h0, 1'b0, `DPAT_ACT_ONLY, 3'h0, 1'b1, 8'h03, 8'h00);
    sw = 8'h01;
    step(4);
    `CHK("raw", 8'h01, raw)
    tick(3'h4);
    tick(3'h4);
    `CHK("state early", 1'b0, st[0])
    tick(3'h4);
    `CHK("state", 1'b1, st[0])
    `CHK("alarm only", 8'h01, alm)
    `CHK("no stop", 1'b0, stop)
    pt(3'h0, 1'b0, `DPAT_ACT_ONLY, 3'h0, 1'b0, 8'h03, 8'h00);
    `CHK("open polarity", 8'h00, alm)
    fin("debounce");
    // Clear while the alarm stands must not release the stop
    pt(3'h1, 1'b0, `DPAT_ACT_STOP, 3'h0, 1'b0, 8'h00, 8'h00);
    step(2);
    `CHK("stop set", 1'b1, stop)
    aclr = 1'b1;
    step(1);
    aclr = 1'b0;
    sw = 8'h03;
    step(5);
    `CHK("stop held", 1'b1, stop)
    aclr = 1'b1;
    step(1);
    aclr = 1'b0;
    step(1);
    `CHK("stop clear", 1'b0, stop)
    fin("stop");
    pt(3'h2, 1'b0, `DPAT_ACT_MALF, 3'h0, 1'b1, 8'h00, 8'h00);
    sw = 8'h07;
    for (i = 0; i < 10 && malf !== 1'b1; i++) step(1);
    if (i == 10) begin
      num_errors++;
      test_done();
    end
    `CHK("malf point", 3'h2, mpt)
    fin("malfunction");
    // Point 3 drives output point 7; point 4 is disabled
    pt(3'h7, 1'b1, `DPAT_ACT_DIS, 3'h0, 1'b0, 8'h00, 8'h00);
    pt(3'h3, 1'b0, `DPAT_ACT_DRV, 3'h7, 1'b1, 8'h00, 8'h33);
    pt(3'h4, 1'b0, `DPAT_ACT_DIS, 3'h0, 1'b1, 8'h00, 8'hFF);
    sw = 8'h1F;
    step(6);
    `CHK("drive oe", 1'b1, oe[7])
    `CHK("drive on", 1'b1, out[7])
    `CHK("disabled", 1'b0, alm[4])
    sw = 8'h17;
    step(6);
    `CHK("drive off", 1'b0, out[7])
    pcmd = 8'h80;
    step(2);
    `CHK("command", 1'b1, out[7])
    prsel = 3'h4;
    step(2);
    `CHK("point id", 8'hFF, ptid)
    fin("drive");
    // Channel 0: three pulses a unit, 2-minute rate, 2-day period
    tid = 8'h5A;
    tw(3'h0, 5'h1F, 20'h0_0003, 11'h002, 9'h002);
    tw(3'h1, 5'h00, 20'h0_0001, 11'h000, 9'h001);
    tick(3'h4);
    field_u.burst(8'h03, 6);
    step(4);
    tick(3'h4);
    `CHK("freq", 16'h0006, freq)
    `CHK("total", 32'h0000_0002, total)
    `CHK("tot id", 8'h5A, tido)
    `CHK("unit", 5'h1F, unito)
    tick(3'h2);
    step(300);
    tick(3'h2);
    step(300);
    `CHK("rate", 32'h0000_05A0, rate)
    trsel = 3'h1;
    step(2);
    `CHK("total ch1", 32'h0000_0006, total)
    `CHK("rate ch1", 32'h0000_0000, rate)
    `CHK("unit ch1", 5'h00, unito)
    trsel = 3'h0;
    tick(3'h1);
    step(1);
    `CHK("history", 32'h0000_0002, hist)
    `CHK("period", 32'h0000_0002, prd)
    tick(3'h1);
    hidx = 6'h01;
    step(2);
    `CHK("previous", 32'h0000_0002, prev)
    `CHK("period new", 32'h0000_0000, prd)
    `CHK("history 2", 32'h0000_0000, hist)
    field_u.burst(8'h01, 3);
    step(4);
    `CHK("period run", 32'h0000_0001, prd)
    clr(2'h1);
    `CHK("period clr", 32'h0000_0000, prd)
    `CHK("total kept", 32'h0000_0003, total)
    clr(2'h2);
    `CHK("total clr", 32'h0000_0000, total)
    fin("totalizer");
    test_done();
  end
endmodule // tb
`default_nettype wire
